// ---- include/smf_pkg.sv ----
package smf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int N_CH    = 18;
  localparam int N_PAIRS = N_CH * (N_CH - 1) / 2;
  localparam int CNT_W   = 24;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int HALT_LEAD_MS    = 250;
  localparam int HALT_LEAD_CYC   = HALT_LEAD_MS * CYC_PER_MS;
  localparam int DEBOUNCE_MS     = 10;
  localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
  localparam int BLINK_HZ        = 2;
  localparam int BLINK_DUTY_PCT  = 25;
  localparam int BLINK_PERIOD_CYC = CLK_HZ / BLINK_HZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_YINH     = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0C;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;

  localparam int CTRL_RELAY_TEST = 0;

  // Yellow inhibit: channels 13..16 (bits 12..15)
  localparam logic [17:0] YINH_RST = 18'h0F000;

  // Status fields
  localparam int ST_B_STATE   = 0;
  localparam int ST_B_CONF    = 3;
  localparam int ST_B_CFAULT  = 4;
  localparam int ST_B_ABSENT  = 5;
  localparam int ST_B_CARD16  = 6;

  // Interrupt status bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_FAIL  = 0;
  localparam int IRQ_CARD  = 1;
  localparam int IRQ_RESET = 2;

  typedef enum logic [2:0] {
    ST_NORMAL  = 3'b001,
    ST_FAILED  = 3'b010,
    ST_RELEASE = 3'b100
  } smf_state_t;

endpackage

// ---- hw/smf_debounce.sv ----
`timescale 1ns/1ns
module smf_debounce #(
  parameter int W          = 8,
  parameter int STABLE_CYC = smf_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);

  localparam logic [smf_pkg::CNT_W-1:0] STABLE_END = smf_pkg::CNT_W'(STABLE_CYC - 1);

  logic [W-1:0]              last;
  logic [W-1:0]              next_last;
  logic [W-1:0]              next_clean;
  logic [smf_pkg::CNT_W-1:0] cnt;
  logic [smf_pkg::CNT_W-1:0] next_cnt;

  // ----------------------------------------------------------------
  // Whole vector must hold still before it is passed on
  // ----------------------------------------------------------------
  always_comb
  begin
    next_last  = raw;
    next_clean = clean;
    next_cnt   = cnt;
    if (raw != last)
    begin
      next_cnt = '0;
    end
    else if (cnt == STABLE_END)
    begin
      next_clean = last;
    end
    else
    begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last  <= '0;
      clean <= '0;
      cnt   <= '0;
    end
    else
    begin
      last  <= next_last;
      clean <= next_clean;
      cnt   <= next_cnt;
    end
  end

endmodule

// ---- hw/smf_failsafe.sv ----
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module smf_failsafe #(
  parameter int N_CH             = smf_pkg::N_CH,
  parameter int HALT_LEAD_CYC    = smf_pkg::HALT_LEAD_CYC,
  parameter int DEBOUNCE_CYC     = smf_pkg::DEBOUNCE_CYC,
  parameter int BLINK_PERIOD_CYC = smf_pkg::BLINK_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Field activity
  input  wire logic [N_CH-1:0]                  chan_green,
  input  wire logic [N_CH-1:0]                  chan_yellow,
  // Program card
  input  wire logic [N_CH*(N_CH-1)/2-1:0]       diode_present,
  input  wire logic [N_CH-1:0]                  yel_jumper,
  input  wire logic                             card_loop,
  input  wire logic                             card_marker16,
  // Reset sources
  input  wire logic                             reset_button,
  input  wire logic                             ext_reset_n,
  // Outputs
  output logic                                  failsafe_relay,
  output logic                                  halt_timing,
  output logic                                  card_absent_fault,
  output logic [15:0]                           chan_flash,
  output logic                                  irq
);

  localparam int NP = N_CH * (N_CH - 1) / 2;
  localparam int DW = NP + N_CH + 2;
  localparam int CW = smf_pkg::CNT_W;
  localparam logic [CW-1:0] HALT_END  = CW'(HALT_LEAD_CYC - 1);
  localparam logic [CW-1:0] BLINK_END = CW'(BLINK_PERIOD_CYC - 1);
  localparam logic [CW-1:0] BLINK_ON  =
    CW'(BLINK_PERIOD_CYC * smf_pkg::BLINK_DUTY_PCT / 100);

  // ----------------------------------------------------------------
  // Debounced card inputs
  // ----------------------------------------------------------------
  logic [DW-1:0]   db_raw;
  logic [DW-1:0]   db_out;
  logic [NP-1:0]   diode_db;
  logic [N_CH-1:0] jumper_db;
  logic            loop_db;
  logic            marker_db;

  assign db_raw = {card_marker16, card_loop, yel_jumper, diode_present};

  smf_debounce #(
    .W          (DW),
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (db_raw),
    .clean   (db_out)
  );

  assign diode_db  = db_out[NP-1:0];
  assign jumper_db = db_out[NP+N_CH-1:NP];
  assign loop_db   = db_out[DW-2];
  assign marker_db = db_out[DW-1];

  // ----------------------------------------------------------------
  // Card type
  // ----------------------------------------------------------------
  logic card_absent;
  logic card16;

  assign card_absent = !loop_db;
  assign card16      = loop_db && marker_db;

  // ----------------------------------------------------------------
  // Conflict evaluation
  // ----------------------------------------------------------------
  logic [17:0]     yinh;
  logic [N_CH-1:0] active;
  logic [NP-1:0]   pair_hit;
  logic            conflict;

  assign active = chan_green | (chan_yellow & ~(jumper_db | N_CH'(yinh)));

  genvar gi;
  genvar gj;
  generate
    for (gi = 0; gi < N_CH - 1; gi++)
    begin : g_i
      for (gj = gi + 1; gj < N_CH; gj++)
      begin : g_j
        localparam int P = gi * (2 * N_CH - gi - 1) / 2 + gj - gi - 1;
        assign pair_hit[P] = diode_db[P] && active[gi] && active[gj];
      end
    end
  endgenerate

  assign conflict = |pair_hit;

  // ----------------------------------------------------------------
  // Reset command, leading edge only
  // ----------------------------------------------------------------
  logic btn_q;
  logic ext_q;
  logic reset_cmd;

  assign reset_cmd = (reset_button && !btn_q) || (!ext_reset_n && ext_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_q <= 1'b1;
      ext_q <= 1'b0;
    end
    else
    begin
      btn_q <= reset_button;
      ext_q <= ext_reset_n;
    end
  end

  // ----------------------------------------------------------------
  // Failed-state sequencing
  // ----------------------------------------------------------------
  smf_pkg::smf_state_t state;
  smf_pkg::smf_state_t next_state;
  logic [CW-1:0]       halt_cnt;
  logic [CW-1:0]       next_halt_cnt;
  logic                conf_lat;
  logic                next_conf_lat;
  logic                next_card_fault;
  logic                next_relay;
  logic                next_halt;
  logic                relay_test;
  logic                fail_cause;

  assign fail_cause = conflict || next_card_fault;

  always_comb
  begin
    next_state      = state;
    next_halt_cnt   = halt_cnt;
    next_conf_lat   = conf_lat || conflict;
    next_card_fault = card_absent_fault || card_absent || card16;
    if (reset_cmd)
    begin
      next_conf_lat   = conflict;
      next_card_fault = card_absent || card16;
    end
    unique case (state)
      smf_pkg::ST_NORMAL:
      begin
        if (fail_cause)
        begin
          next_state = smf_pkg::ST_FAILED;
        end
      end
      smf_pkg::ST_FAILED:
      begin
        if (reset_cmd && !fail_cause)
        begin
          next_state    = smf_pkg::ST_RELEASE;
          next_halt_cnt = '0;
        end
      end
      smf_pkg::ST_RELEASE:
      begin
        next_halt_cnt = halt_cnt + 1'b1;
        if (fail_cause)
        begin
          next_state = smf_pkg::ST_FAILED;
        end
        else if (halt_cnt == HALT_END)
        begin
          next_state = smf_pkg::ST_NORMAL;
        end
      end
      default:
      begin
        next_state = smf_pkg::ST_FAILED;
      end
    endcase
    next_relay = (next_state == smf_pkg::ST_NORMAL) && !relay_test;
    next_halt  = (next_state == smf_pkg::ST_FAILED);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state             <= smf_pkg::ST_NORMAL;
      halt_cnt          <= '0;
      conf_lat          <= 1'b0;
      card_absent_fault <= 1'b0;
      failsafe_relay    <= 1'b0;
      halt_timing       <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      halt_cnt          <= next_halt_cnt;
      conf_lat          <= next_conf_lat;
      card_absent_fault <= next_card_fault;
      failsafe_relay    <= next_relay;
      halt_timing       <= next_halt;
    end
  end

  // ----------------------------------------------------------------
  // Wrong-card flash, 2 Hz at 25 % duty
  // ----------------------------------------------------------------
  logic [CW-1:0] blink_cnt;
  logic [CW-1:0] next_blink_cnt;
  logic [15:0]   next_flash;

  always_comb
  begin
    // Held at zero until a wrong card shows, so the first flash is full width
    next_blink_cnt = (!card16 || blink_cnt == BLINK_END) ? '0 : blink_cnt + 1'b1;
    next_flash     = {16{card16 && (blink_cnt < BLINK_ON)}};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt  <= '0;
      chan_flash <= '0;
    end
    else
    begin
      blink_cnt  <= next_blink_cnt;
      chan_flash <= next_flash;
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupts
  // ----------------------------------------------------------------
  logic [smf_pkg::IRQ_W-1:0] irq_stat;
  logic [smf_pkg::IRQ_W-1:0] irq_mask;
  logic [smf_pkg::IRQ_W-1:0] next_irq_stat;
  logic [smf_pkg::IRQ_W-1:0] next_irq_mask;
  logic [smf_pkg::IRQ_W-1:0] ev;
  logic [17:0]               next_yinh;
  logic                      next_relay_test;
  logic [31:0]               next_prdata;
  logic [31:0]               status;
  logic                      hit;
  logic                      wr;

  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign pslverr = psel && penable && !hit;
  assign irq     = |(irq_stat & irq_mask);

  always_comb
  begin
    status = '0;
    status[smf_pkg::ST_B_STATE +: 3] = state;
    status[smf_pkg::ST_B_CONF]       = conf_lat;
    status[smf_pkg::ST_B_CFAULT]     = card_absent_fault;
    status[smf_pkg::ST_B_ABSENT]     = card_absent;
    status[smf_pkg::ST_B_CARD16]     = card16;
    hit = (paddr == smf_pkg::A_CTRL) || (paddr == smf_pkg::A_YINH) ||
          (paddr == smf_pkg::A_STATUS) || (paddr == smf_pkg::A_IRQ_STAT) ||
          (paddr == smf_pkg::A_IRQ_MASK);
    ev                      = '0;
    ev[smf_pkg::IRQ_FAIL]   = (state != smf_pkg::ST_FAILED) &&
                              (next_state == smf_pkg::ST_FAILED);
    ev[smf_pkg::IRQ_CARD]   = next_card_fault && !card_absent_fault;
    ev[smf_pkg::IRQ_RESET]  = reset_cmd;
    next_relay_test = relay_test;
    next_yinh       = yinh;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    if (wr)
    begin
      unique case (paddr)
        smf_pkg::A_CTRL:     next_relay_test = pwdata[smf_pkg::CTRL_RELAY_TEST];
        smf_pkg::A_YINH:     next_yinh       = pwdata[17:0];
        smf_pkg::A_IRQ_STAT: next_irq_stat   = irq_stat & ~pwdata[smf_pkg::IRQ_W-1:0];
        smf_pkg::A_IRQ_MASK: next_irq_mask   = pwdata[smf_pkg::IRQ_W-1:0];
        default:             next_irq_mask   = irq_mask;
      endcase
    end
    next_irq_stat = next_irq_stat | ev;
    next_prdata   = prdata;
    if (psel && !penable)
    begin
      unique case (paddr)
        smf_pkg::A_CTRL:     next_prdata = {31'h0, relay_test};
        smf_pkg::A_YINH:     next_prdata = {14'h0, yinh};
        smf_pkg::A_STATUS:   next_prdata = status;
        smf_pkg::A_IRQ_STAT: next_prdata = {29'h0, irq_stat};
        smf_pkg::A_IRQ_MASK: next_prdata = {29'h0, irq_mask};
        default:             next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_test <= 1'b0;
      yinh       <= smf_pkg::YINH_RST;
      irq_mask   <= '0;
      irq_stat   <= '0;
      prdata     <= '0;
    end
    else
    begin
      relay_test <= next_relay_test;
      yinh       <= next_yinh;
      irq_mask   <= next_irq_mask;
      irq_stat   <= next_irq_stat;
      prdata     <= next_prdata;
    end
  end

endmodule

// ---- sim/smf_failsafe_props.sv ----
`timescale 1ns/1ns
module smf_failsafe_props #(
  parameter int HALT_LEAD_CYC = 20
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Reset sources
  input wire logic        reset_button,
  input wire logic        ext_reset_n,
  // Outputs
  input wire logic        failsafe_relay,
  input wire logic        halt_timing,
  input wire logic        card_absent_fault,
  input wire logic [15:0] chan_flash
);
  logic        halt_q;
  logic        btn_q;
  logic        ext_q;
  logic        rst_ev;
  logic [23:0] cnt;

  // -------------------------------------
  // Reset edges and halt-to-relay lead
  // -------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      halt_q <= 1'b0;
      btn_q  <= 1'b0;
      ext_q  <= 1'b1;
      rst_ev <= 1'b0;
      cnt    <= 24'h0;
    end
    else
    begin
      halt_q <= halt_timing;
      btn_q  <= reset_button;
      ext_q  <= ext_reset_n;
      rst_ev <= (reset_button && !btn_q) || (!ext_reset_n && ext_q);
      if (halt_timing)
        cnt <= 24'h0;
      else if (halt_q)
        cnt <= 24'h1;
      else if (failsafe_relay)
        cnt <= 24'h0;
      else if (cnt != 24'h0)
        cnt <= cnt + 24'h1;
    end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RELAY_OFF: assert property (halt_timing |-> !failsafe_relay)
    else $error("relay energized while halted");
  AST_LEAD: assert property ($rose(failsafe_relay) && cnt != 24'h0 |-> cnt == HALT_LEAD_CYC)
    else $error("halt lead time wrong");
  AST_LEAD_HOLD: assert property ($fell(halt_timing) |-> !failsafe_relay [*8])
    else $error("relay rose too soon");
  AST_RST_EDGE: assert property ($fell(halt_timing) |-> rst_ev)
    else $error("failed state left without reset edge");
  AST_CARD_HOLD: assert property ($fell(card_absent_fault) |-> rst_ev)
    else $error("card fault cleared without reset edge");
  AST_FLASH_ALL: assert property (chan_flash != 16'h0 |-> chan_flash == 16'hFFFF)
    else $error("flash not on all channels");
  AST_FLASH_ON: assert property ($rose(chan_flash[0]) |-> chan_flash[0] [*2] ##1 !chan_flash[0])
    else $error("flash on time wrong");
  AST_FLASH_OFF: assert property ($fell(chan_flash[0]) |-> !chan_flash[0] [*6])
    else $error("flash off time wrong");

  COV_RELEASE: cover property ($fell(halt_timing));
  COV_CARD: cover property ($rose(card_absent_fault));
  COV_FLASH: cover property ($rose(chan_flash[0]));
endmodule

bind smf_failsafe smf_failsafe_props #(.HALT_LEAD_CYC(HALT_LEAD_CYC)) u_props (
  .pclk, .presetn, .reset_button, .ext_reset_n, .failsafe_relay,
  .halt_timing, .card_absent_fault, .chan_flash);

// ---- sim/smf_cabinet_model.sv ----
`timescale 1ns/1ns
module smf_cabinet_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Monitor outputs
  input  wire logic        failsafe_relay,
  input  wire logic        halt_timing,
  // Cabinet view
  output logic             on_flash,
  output logic [15:0]      lead
);
  logic        halt_q;
  logic        relay_q;
  logic [15:0] cnt;

  // Relay at rest closes the flash transfer
  assign on_flash = !failsafe_relay;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      halt_q  <= 1'b0;
      relay_q <= 1'b0;
      cnt     <= 16'h0;
      lead    <= 16'h0;
    end
    else
    begin
      halt_q  <= halt_timing;
      relay_q <= failsafe_relay;
      if (halt_timing)
        cnt <= 16'h0;
      else if (halt_q)
        cnt <= 16'h1;
      else if (failsafe_relay)
        cnt <= 16'h0;
      else if (cnt != 16'h0)
        cnt <= cnt + 16'h1;
      if (failsafe_relay && !relay_q && cnt != 16'h0)
        lead <= cnt;
    end
endmodule

// ---- sim/signal_monitor_failsafe_outputs_tb_top.sv ----
`timescale 1ns/1ns
module signal_monitor_failsafe_outputs_tb_top;
  localparam int H = 20;
  logic         pclk, presetn, psel, penable, pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, err;
  logic [17:0]  chan_green, chan_yellow, yel_jumper;
  logic [152:0] diode_present, one;
  logic         card_loop, card_marker16, reset_button, ext_reset_n;
  logic         failsafe_relay, halt_timing, card_absent_fault, irq, on_flash;
  logic [15:0]  chan_flash, lead;
  int           fail_count, tests_run, p, n;

  smf_failsafe #(.HALT_LEAD_CYC(H), .DEBOUNCE_CYC(4), .BLINK_PERIOD_CYC(8)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chan_green, .chan_yellow, .diode_present,
    .yel_jumper, .card_loop, .card_marker16, .reset_button, .ext_reset_n,
    .failsafe_relay, .halt_timing, .card_absent_fault, .chan_flash, .irq);
  smf_cabinet_model u_cab (.pclk, .presetn, .failsafe_relay, .halt_timing,
    .on_flash, .lead);

  // -------------------------------------
  // Tasks
  // -------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    cyc(1);
    while (pready !== 1'b1 && k < 10)
    begin
      k++;
      cyc(1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
    if (k == 10)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic push;
    reset_button <= 1'b1;
    cyc(3);
    reset_button <= 1'b0;
    cyc(1);
  endtask

  task automatic wait_relay;
    int k;
    k = 0;
    while (failsafe_relay !== 1'b1 && k < 60)
    begin
      k++;
      cyc(1);
    end
    if (k == 60)
    begin
      fail_count++;
      report_and_stop();
    end
    cyc(1);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    cyc(100000);
    fail_count++;
    report_and_stop();
  end

  // -------------------------------------
  // Main sequence
  // -------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, reset_button, card_marker16} = '0;
    {paddr, pwdata, chan_green, chan_yellow, yel_jumper} = '0;
    diode_present = '1;
    card_loop = 1'b1;
    ext_reset_n = 1'b1;
    fail_count = 0;
    tests_run = 0;
    cyc(10);
    presetn <= 1'b1;
    cyc(10);
    check(card_absent_fault, 1);
    check(on_flash, 1);
    push;
    wait_relay;
    check(lead, H);
    apb(1'b0, smf_pkg::A_YINH, 0);
    check(rd, 32'h0F000);
    apb(1'b0, smf_pkg::A_STATUS, 0);
    check(rd, 32'h1);
    apb(1'b0, 8'h14, 0);
    check(err, 1);
    apb(1'b1, smf_pkg::A_IRQ_STAT, 7);
    apb(1'b1, smf_pkg::A_CTRL, 1);
    cyc(1);
    check({failsafe_relay, halt_timing}, 0);
    apb(1'b1, smf_pkg::A_CTRL, 0);
    cyc(2);
    check(failsafe_relay, 1);
    chan_yellow <= 18'h03000;
    cyc(8);
    check(halt_timing, 0);
    yel_jumper <= 18'h3;
    cyc(8);
    chan_yellow <= 18'h3;
    cyc(8);
    check(halt_timing, 0);
    yel_jumper <= 18'h0;
    cyc(8);
    check({halt_timing, failsafe_relay}, 2);
    apb(1'b0, smf_pkg::A_IRQ_STAT, 0);
    check(rd, 1);
    check(irq, 0);
    apb(1'b1, smf_pkg::A_IRQ_MASK, 1);
    check(irq, 1);
    push;
    check(halt_timing, 1);
    reset_button <= 1'b1;
    cyc(3);
    chan_yellow <= 18'h0;
    cyc(4);
    check(halt_timing, 1);
    reset_button <= 1'b0;
    cyc(2);
    push;
    check({halt_timing, failsafe_relay}, 0);
    wait_relay;
    check(lead, H);
    apb(1'b1, smf_pkg::A_IRQ_STAT, 7);
    check(irq, 0);
    for (int i = 0; i < 17; i++)
      for (int j = i + 1; j < 18; j++)
      begin
        p = i * (35 - i) / 2 + j - i - 1;
        one = '0;
        one[p] = 1'b1;
        diode_present <= ~one;
        cyc(8);
        chan_green <= (18'h1 << i) | (18'h1 << j);
        cyc(8);
        check(halt_timing, 0);
        diode_present <= one;
        cyc(8);
        check(halt_timing, 1);
        chan_green <= 18'h0;
        push;
        wait_relay;
      end
    diode_present <= '1;
    card_loop <= 1'b0;
    cyc(8);
    check({card_absent_fault, failsafe_relay}, 2);
    card_loop <= 1'b1;
    cyc(8);
    check(card_absent_fault, 1);
    push;
    wait_relay;
    check(card_absent_fault, 0);
    card_marker16 <= 1'b1;
    cyc(10);
    check(card_absent_fault, 1);
    apb(1'b0, smf_pkg::A_STATUS, 0);
    check(rd[6], 1);
    n = 0;
    repeat (16)
    begin
      cyc(1);
      if (chan_flash === 16'hFFFF)
        n++;
    end
    check(n, 4);
    p = 0;
    while (chan_flash !== 16'hFFFF && p < 20)
    begin
      p++;
      cyc(1);
    end
    card_marker16 <= 1'b0;
    cyc(10);
    push;
    wait_relay;
    check(chan_flash, 0);
    chan_green <= 18'h5;
    cyc(3);
    check(halt_timing, 1);
    chan_green <= 18'h0;
    ext_reset_n <= 1'b0;
    cyc(3);
    check(halt_timing, 0);
    ext_reset_n <= 1'b1;
    wait_relay;
    report_and_stop();
  end
endmodule
